// ==== adc_serial_port_config_tb_top.sv ====
// self-checking bench: buffer fill, internal and external frames, parallel pads
// assumes asp_host_model on the serial side; a queue stands for the result buffer
`timescale 1ns/10ps
module adc_serial_port_config_tb_top import asp_pkg::*; ;
   logic        clk, rst_n, wr, rd, kind, busy, valid, ready;
   logic        req, sclk_h, sclk_o, sclk_oe, sdo, mark;
   logic [3:0]  addr, cfg, pad_o, pad_oe;
   logic [31:0] wdata, rdata;
   asp_word_t   data;
   asp_word_t   q[$];
   int          fails, checks, cyc;
   wire  [3:0]  pad_in  = (pad_oe & pad_o) | (~pad_oe & cfg);
   wire         sclk_in = sclk_oe ? sclk_o : sclk_h;

   asp_serial_port i_asp_serial_port (
      .sys_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .port_kind_select_i(kind),
      .shared_pad_i(pad_in), .shared_pad_o(pad_o), .shared_pad_oe_o(pad_oe),
      .conv_busy_i(busy), .result_valid_i(valid), .result_data_i(data),
      .result_ready_o(ready), .read_req_i(req), .sclk_pad_i(sclk_in),
      .sclk_pad_o(sclk_o), .sclk_pad_oe_o(sclk_oe), .serial_result_out_o(sdo),
      .frame_marker_o(mark));
   asp_host_model i_asp_host_model (
      .sys_clk_i(clk), .sclk_in_i(sclk_in), .sdo_i(sdo), .marker_i(mark),
      .invert_i(cfg[2]), .sclk_o(sclk_h), .read_req_o(req));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic give_verdict;
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // entered just after a rising edge; returns at the accepting edge with valid still up
   task automatic push(input asp_word_t w);
      int k;
      k = 0;
      valid <= 1'b1;
      data  <= w;
      @(posedge clk);
      while (ready !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      if (k == 50) begin
         fails++;
         $display("[ERR] push accept expected 1 seen %b", ready);
      end
      q.push_back(w);
   endtask

   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   initial begin
      logic [31:0] r;
      asp_word_t   w;
      asp_word_t   e;
      logic        cb;
      logic        ch;
      int          act;
      void'($urandom(32'h80b12b96));
      rst_n = 1'b0;
      addr  = 4'h0;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
      kind  = 1'b1;
      busy  = 1'b1;
      valid = 1'b0;
      data  = 16'h0;
      cfg   = 4'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      reg_rd(4'h0, r);
      chk("ctrl", 32'h1, r);
      reg_rd(4'hc, r);
      chk("unmapped", 32'h0, r);
      reg_wr(4'h4, 32'hffffffff);
      reg_rd(4'h4, r);
      chk("status", 32'h4, r);
      @(posedge clk);
      for (int i = 0; i < 8; i++) push(16'($urandom));
      valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("ready full", 32'h0, {31'h0, ready});
      reg_rd(4'h4, r);
      chk("level", 32'h8, {28'h0, r[7:4]});
      // read after convert, every polarity and invert, divider varied
      for (int m = 0; m < 4; m++) begin
         cfg <= {1'b0, m[1], m[0], 1'b0};
         reg_wr(4'h0, {29'h0, m[1:0], 1'b1});
         repeat (2) @(posedge clk);
         fork
            i_asp_host_model.read_int(m[0], w, act);
            busy <= 1'b0;
         join
         busy <= 1'b1;
         e = q.pop_front();
         chk("rac word", {16'h0, e}, {16'h0, w});
         chk("rac marker", 32'h10, 32'(act));
         chk("sclk oe int", 32'h1, {31'h0, sclk_oe});
      end
      // read during conversion: frame starts on busy rise
      cfg <= 4'b1000;
      repeat (3) @(posedge clk);
      busy <= 1'b0;
      repeat (3) @(posedge clk);
      fork
         i_asp_host_model.read_int(1'b0, w, act);
         busy <= 1'b1;
      join
      e = q.pop_front();
      chk("rdc word", {16'h0, e}, {16'h0, w});
      // external clock, inverted, with a chained bit
      cb = 1'($urandom);
      cfg <= {cb, 1'b1, 1'b0, 1'b1};
      repeat (3) @(posedge clk);
      chk("sclk oe ext", 32'h0, {31'h0, sclk_oe});
      i_asp_host_model.read_ext(w, ch);
      e = q.pop_front();
      chk("ext word", {16'h0, e}, {16'h0, w});
      chk("chain bit", {31'h0, cb}, {31'h0, ch});
      chk("ext marker", 32'h0, {31'h0, mark});
      // parallel: pads carry bits 7..4
      @(posedge clk);
      i_asp_host_model.set_req(1'b0);
      kind <= 1'b0;
      repeat (3) @(posedge clk);
      i_asp_host_model.set_req(1'b1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      e = q.pop_front();
      chk("par pads", {28'h0, e[7:4]}, {28'h0, pad_o});
      chk("par oe", 32'hf, {28'h0, pad_oe});
      reg_rd(4'h8, r);
      chk("result", {16'h0, e}, r);
      give_verdict();
   end
endmodule

// ==== asp_fifo.sv ====
// result buffer: width and depth set the storage, valid/ready on both sides
// assumes depth is a power of two; ready on the fill side is a flip-flop
`timescale 1ns/10ps
module asp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic  sys_clk_i,
   input  wire logic  reset_n_i,
   asp_fifo_if.sink   push_if,
   asp_fifo_if.source pop_if
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             full_reg;
   wire              push_ok = push_if.valid & ~full_reg;
   wire              pop_ok  = pop_if.ready & (count_reg != '0);

   assign count_next    = count_reg + {{AW{1'b0}}, push_ok} - {{AW{1'b0}}, pop_ok};
   assign push_if.ready = ~full_reg;
   assign pop_if.valid  = (count_reg != '0);
   assign pop_if.data   = mem_reg[rd_ptr_reg];

   always_ff @(posedge sys_clk_i) begin
      if (push_ok) begin
         mem_reg[wr_ptr_reg] <= push_if.data;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         full_reg   <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push_ok);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop_ok);
         count_reg  <= count_next;
         full_reg   <= (count_next == (AW+1)'(DEPTH));
      end
   end
endmodule

// ==== asp_fifo_if.sv ====
// valid/ready stream between the serial port and its result buffer
// assumes one clock domain; the producer drives valid and data
`timescale 1ns/10ps
interface asp_fifo_if #(
   parameter int WIDTH = 16
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport sink   (input valid, input data, output ready);
   modport source (output valid, output data, input ready);
endinterface

// ==== asp_host_model.sv ====
// host on the serial side: supplies the external clock and read request, collects bits
// assumes sdo and the device clock are sampled at sys_clk_i; one frame at a time
`timescale 1ns/10ps
module asp_host_model (
   input  wire logic sys_clk_i,
   input  wire logic sclk_in_i,
   input  wire logic sdo_i,
   input  wire logic marker_i,
   input  wire logic invert_i,
   output logic      sclk_o,
   output logic      read_req_o
);
   logic eff_reg;

   initial begin
      eff_reg    = 1'b0;
      read_req_o = 1'b0;
   end
   // clock stands at its idle level between frames
   assign sclk_o = eff_reg ^ invert_i;

   task automatic set_req(input logic v);
      read_req_o <= v;
   endtask

   // bit taken before each rising edge; the 17th sample is the chained bit
   task automatic read_ext(output logic [15:0] w, output logic chain_bit);
      read_req_o <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      for (int i = 15; i >= 0; i--) begin
         w[i] = sdo_i;
         eff_reg <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         eff_reg <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
      chain_bit = sdo_i;
      read_req_o <= 1'b0;
   endtask

   // counts samples that see the marker at its active level
   task automatic read_int(input logic pol, output logic [15:0] w, output int act);
      int   n;
      logic e;
      logic p;
      n   = 0;
      act = 0;
      p   = sclk_in_i ^ invert_i;
      for (int k = 0; k < 800 && n < 16; k++) begin
         @(posedge sys_clk_i);
         e = sclk_in_i ^ invert_i;
         if (e && !p) begin
            w[15-n] = sdo_i;
            act += (marker_i === ~pol) ? 1 : 0;
            n++;
         end
         p = e;
      end
   endtask
endmodule

// ==== asp_pkg.sv ====
// types shared by the serial port modules
// assumes asp_regs.svh is on the include path
package asp_pkg;

   typedef enum logic [2:0] {
      ASP_ST_IDLE  = 3'b001,
      ASP_ST_SHIFT = 3'b010,
      ASP_ST_HOLD  = 3'b100
   } asp_state_t;

   typedef logic [15:0] asp_word_t;

endpackage

// ==== asp_regs.svh ====
// register offsets, field positions, reset values and timing counts of the serial port
// assumes a 100 MHz system clock and a 4-bit word-aligned register address
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

`define ASP_ADDR_CTRL       4'h0
`define ASP_ADDR_STATUS     4'h4
`define ASP_ADDR_RESULT     4'h8

`define ASP_CTRL_ENABLE     0
`define ASP_CTRL_DIV_LO     1
`define ASP_CTRL_DIV_HI     2
`define ASP_CTRL_RESET      3'h1

`define ASP_STAT_FRAME      0
`define ASP_STAT_EXT        1
`define ASP_STAT_SERIAL     2
`define ASP_STAT_READ_MODE  3
`define ASP_STAT_LVL_LO     4
`define ASP_STAT_LVL_HI     7

`define ASP_WORD_BITS       5'h10
`define ASP_FIFO_DEPTH      8
`define ASP_FIFO_LVL_W      4
`define ASP_SCLK_HALF_BASE  8'h02

`endif

// ==== asp_serial_port.sv ====
// serial output port of a 16-bit converter: pin sharing, clocking, framing, chaining
// assumes all pins synchronous to sys_clk_i and a host keeping configuration static
`timescale 1ns/10ps
`include "asp_regs.svh"
module asp_serial_port import asp_pkg::*; (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   input  wire logic        port_kind_select_i,
   input  wire logic [3:0]  shared_pad_i,
   output logic      [3:0]  shared_pad_o,
   output logic      [3:0]  shared_pad_oe_o,
   input  wire logic        conv_busy_i,
   input  wire logic        result_valid_i,
   input  wire logic [15:0] result_data_i,
   output logic             result_ready_o,
   input  wire logic        read_req_i,
   input  wire logic        sclk_pad_i,
   output logic             sclk_pad_o,
   output logic             sclk_pad_oe_o,
   output logic             serial_result_out_o,
   output logic             frame_marker_o
);

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
      hit = (addr == offs);
   endfunction

   asp_fifo_if #(.WIDTH(16)) in_if ();
   asp_fifo_if #(.WIDTH(16)) out_if ();

   asp_state_t  state_reg;
   asp_state_t  state_next;
   logic [2:0]  ctrl_reg;
   logic        ext_reg;
   logic        pol_reg;
   logic        inv_reg;
   logic        rdm_reg;
   logic        chain_reg;
   logic        busy_d_reg;
   logic        req_d_reg;
   logic        sclk_d_reg;
   logic        ck_reg;
   logic [7:0]  div_cnt_reg;
   logic [4:0]  bit_cnt_reg;
   asp_word_t   sr_reg;
   asp_word_t   last_reg;
   logic [3:0]  lvl_reg;
   logic [31:0] rdata_reg;
   logic        sdo_reg;
   logic        sync_reg;
   logic        sclk_o_reg;
   logic        sclk_oe_reg;
   logic [3:0]  pad_o_reg;
   logic [3:0]  pad_oe_reg;

   // decode and selection
   wire        serial_mode = port_kind_select_i;
   wire        enabled     = ctrl_reg[`ASP_CTRL_ENABLE];
   wire        idle        = (state_reg == ASP_ST_IDLE);
   wire        shifting    = (state_reg == ASP_ST_SHIFT);
   wire        int_rac     = ~ext_reg & ~rdm_reg;
   wire [1:0]  div_eff     = int_rac ? ctrl_reg[`ASP_CTRL_DIV_HI:`ASP_CTRL_DIV_LO]
                                     : 2'h0;
   wire [7:0]  half_per    = `ASP_SCLK_HALF_BASE << div_eff;
   wire        div_wrap    = (div_cnt_reg == half_per - 8'h01);
   wire        int_rise    = shifting & div_wrap & ~ck_reg;
   wire        sclk_eff    = sclk_pad_i ^ inv_reg;
   wire        ext_rise    = shifting & sclk_eff & ~sclk_d_reg;
   wire        tick        = ext_reg ? ext_rise : int_rise;
   wire        req_rise    = read_req_i & ~req_d_reg;
   wire        busy_rise   = conv_busy_i & ~busy_d_reg;
   wire        start_ext   = ext_reg & req_rise;
   wire        start_dur   = ~ext_reg & rdm_reg & busy_rise;
   wire        start_aft   = int_rac & ~conv_busy_i;
   wire        start       = serial_mode & enabled & idle & out_if.valid
                             & (start_ext | start_dur | start_aft);
   wire        par_pop     = ~serial_mode & enabled & req_rise & out_if.valid;
   wire        last_bit    = ~ext_reg & tick & (bit_cnt_reg == `ASP_WORD_BITS - 5'h01);
   wire        ck_next     = (shifting & div_wrap & ~ext_reg) ? ~ck_reg
                             : (idle ? 1'b0 : ck_reg);
   wire [31:0] rdata_sel   = hit(reg_addr_i, `ASP_ADDR_CTRL)   ? {29'h0, ctrl_reg} :
                             hit(reg_addr_i, `ASP_ADDR_STATUS) ? {24'h0, lvl_reg, rdm_reg,
                                                                  serial_mode, ext_reg,
                                                                  shifting} :
                             hit(reg_addr_i, `ASP_ADDR_RESULT) ? {16'h0, last_reg} :
                                                                 32'h0;

   assign in_if.valid     = result_valid_i;
   assign in_if.data      = result_data_i;
   assign out_if.ready    = start | par_pop;
   assign result_ready_o  = in_if.ready;

   asp_fifo #(
      .WIDTH (16),
      .DEPTH (`ASP_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .push_if   (in_if),
      .pop_if    (out_if)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ASP_ST_IDLE: begin
            if (start) begin
               state_next = ASP_ST_SHIFT;
            end
         end
         ASP_ST_SHIFT: begin
            if (ext_reg & ~read_req_i) begin
               state_next = ASP_ST_IDLE;
            end else if (last_bit) begin
               state_next = ASP_ST_HOLD;
            end
         end
         ASP_ST_HOLD: begin
            // wait for the conversion to end; while conv_busy_i stays low the next frame follows at once; in read-during mode (rdm_reg) leave at once
            if (~conv_busy_i | rdm_reg) begin
               state_next = ASP_ST_IDLE;
            end
         end
         default: begin
            state_next = ASP_ST_IDLE;
         end
      endcase
   end

   // configuration is frozen during a frame; changes mid-frame would tear it
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {ext_reg, pol_reg, inv_reg, rdm_reg} <= 4'h0;
      end else if (idle & serial_mode) begin
         {rdm_reg, inv_reg, pol_reg, ext_reg} <= shared_pad_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chain_reg  <= 1'b0;
         busy_d_reg <= 1'b0;
         req_d_reg  <= 1'b0;
         sclk_d_reg <= 1'b0;
         ck_reg     <= 1'b0;
         state_reg  <= ASP_ST_IDLE;
      end else begin
         chain_reg  <= shared_pad_i[3];
         busy_d_reg <= conv_busy_i;
         req_d_reg  <= read_req_i;
         sclk_d_reg <= sclk_eff;
         ck_reg     <= ck_next;
         state_reg  <= state_next;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt_reg <= 8'h00;
         bit_cnt_reg <= 5'h00;
      end else if (~shifting | div_wrap) begin
         div_cnt_reg <= 8'h00;
         bit_cnt_reg <= start ? 5'h00 : bit_cnt_reg + 5'(tick);
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
         bit_cnt_reg <= bit_cnt_reg + 5'(tick);
      end
   end

   // chain data enters at the bottom and needs one full word of shifts
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sr_reg   <= 16'h0000;
         last_reg <= 16'h0000;
      end else if (start | par_pop) begin
         sr_reg   <= out_if.data;
         last_reg <= out_if.data;
      end else if (tick) begin
         sr_reg   <= {sr_reg[14:0], ext_reg & chain_reg};
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= `ASP_CTRL_RESET;
      end else if (reg_wr_i & hit(reg_addr_i, `ASP_ADDR_CTRL)) begin
         ctrl_reg <= reg_wdata_i[2:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lvl_reg   <= 4'h0;
         rdata_reg <= 32'h0;
      end else begin
         lvl_reg   <= lvl_reg + 4'(in_if.valid & in_if.ready)
                      - 4'(out_if.valid & out_if.ready);
         rdata_reg <= reg_rd_i ? rdata_sel : 32'h0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pad
         always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               pad_o_reg[gi]  <= 1'b0;
               pad_oe_reg[gi] <= 1'b0;
            end else begin
               pad_o_reg[gi]  <= ~serial_mode & last_reg[4+gi];
               pad_oe_reg[gi] <= ~serial_mode;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sdo_reg     <= 1'b0;
         sync_reg    <= 1'b0;
         sclk_o_reg  <= 1'b0;
         sclk_oe_reg <= 1'b0;
      end else begin
         // lags the shift register by one edge, so the last bit must still be shown
         sdo_reg     <= shifting & sr_reg[15];
         sync_reg    <= serial_mode & ((shifting & ~ext_reg) ^ pol_reg);
         sclk_o_reg  <= serial_mode & ~ext_reg & (ck_next ^ inv_reg);
         sclk_oe_reg <= serial_mode & ~ext_reg;
      end
   end

   assign reg_rdata_o         = rdata_reg;
   assign shared_pad_o        = pad_o_reg;
   assign shared_pad_oe_o     = pad_oe_reg;
   assign serial_result_out_o = sdo_reg;
   assign frame_marker_o      = sync_reg;
   assign sclk_pad_o          = sclk_o_reg;
   assign sclk_pad_oe_o       = sclk_oe_reg;

   // checks
   sequence s_int_start;
      start & ~ext_reg;
   endsequence

   sequence s_int_frame;
      shifting & ~ext_reg;
   endsequence

   chk_par_pads_out: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !serial_mode ##1 !$past(serial_mode) |-> shared_pad_oe_o == 4'hf)
      else $error("parallel mode did not drive shared pads");

   chk_sclk_dir: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      serial_mode |=> sclk_pad_oe_o == !$past(ext_reg))
      else $error("serial clock direction wrong");

   chk_marker_level: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_int_frame ##0 serial_mode |=> frame_marker_o != $past(pol_reg))
      else $error("frame marker not at active level");

   chk_marker_whole: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_int_start ##1 s_int_frame [*3] |-> ##1 (!serial_mode || frame_marker_o != pol_reg))
      else $error("frame marker dropped during frame");

   chk_read_during: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_int_start ##0 rdm_reg |-> conv_busy_i && !$past(conv_busy_i))
      else $error("read during conversion started outside conversion");

   chk_read_after: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_int_start ##0 !rdm_reg |-> !conv_busy_i)
      else $error("read after conversion started while busy");

   chk_div_ignored: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !int_rac |-> half_per == `ASP_SCLK_HALF_BASE)
      else $error("divider acted outside its mode");

   chk_msb_first: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      start |=> ##1 serial_result_out_o == last_reg[15] || !shifting)
      else $error("first serial bit is not the msb");

   chk_ext_edge: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      shifting && ext_reg && !ext_rise |=> $stable(sr_reg))
      else $error("shift outside active external edge");

   chk_chain_shift: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      tick && ext_reg |=> sr_reg[0] == $past(chain_reg))
      else $error("chain input not shifted in");

endmodule
